/* core/opcr_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 16-bit register port, word addresses as printed
// Notes:   Definitions only
`ifndef OPCR_MAP_SVH
`define OPCR_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OPCR_CTRL_ADDR     16'hC098
`define OPCR_IRQ_STAT_ADDR 16'hC09A
`define OPCR_IRQ_MASK_ADDR 16'hC09C

// ****************************************************************
// Field positions of the port control register
// ****************************************************************
`define OPCR_VBUS_PU_BIT   13
`define OPCR_RX_DIS_BIT    12
`define OPCR_CPUMP_BIT     11
`define OPCR_VBUS_DIS_BIT  10
`define OPCR_DP_PU_BIT     9
`define OPCR_DM_PU_BIT     8
`define OPCR_DP_PD_BIT     7
`define OPCR_DM_PD_BIT     6
`define OPCR_VBUS_LVL_BIT  2
`define OPCR_ID_BIT        1
`define OPCR_VBUS_VLD_BIT  0
`define OPCR_CTRL_WMASK    16'h3FC0
`define OPCR_CTRL_RESET    16'h0000

// ****************************************************************
// Interrupt status layout: one bit per status input change
// ****************************************************************
`define OPCR_IRQ_WIDTH     3
`define OPCR_IRQ_RESET     3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define OPCR_CLK_MHZ       125
`define OPCR_VLD_WAIT_US   10
`define OPCR_VLD_WAIT_CYC  (`OPCR_VLD_WAIT_US * `OPCR_CLK_MHZ)

`endif

/* core/opcr_pkg.sv */
// Purpose: Types shared by the port control register files
// Assumes: Constants come from opcr_map.svh
// Notes:   Types only
package opcr_pkg;
   typedef logic [15:0] opcr_word_t;
   typedef logic [2:0]  opcr_stat_t;
endpackage

/* core/opcr_port_ctrl.sv */
// Purpose: Port control and status register of the dual role port
// Assumes: Synchronous transceiver status; one-cycle register strobes
// Notes:   Read data valid the cycle after the read strobe
//
// Summary of operation
// - Control register at 0xC098, 16 bits, control writable, status read-only.
// - Bit 13 drives the VBUS 500 ohm pull-up enable.
// - Bit 12 powers down and disables the port receiver.
// - Bit 11 turns on the VBUS charge pump.
// - Bit 10 drives the VBUS 2K ohm discharge pull-down enable.
// - Bit 9 enables the D+ pull-up.
// - Bit 8 enables the D- pull-up.
// - Bit 7 enables the D+ pull-down.
// - Bit 6 enables the D- pull-down.
// - These data-line enables override the general USB port control settings.
// - Bit 2 reads the VBUS logic level.
// - Bit 1 reads one when ID pin is not grounded.
// - Bit 0 reads one when VBUS exceeds 4.4V.
`include "opcr_map.svh"
module opcr_port_ctrl
   import opcr_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output      logic [15:0] reg_rdata,
   input  wire logic        vbus_level_in,
   input  wire logic        id_float_in,
   input  wire logic        vbus_valid_in,
   input  wire logic        gen_dp_pu,
   input  wire logic        gen_dm_pu,
   input  wire logic        gen_dp_pd,
   input  wire logic        gen_dm_pd,
   output      logic        vbus_pu_en,
   output      logic        rx_power_down,
   output      logic        charge_pump_on,
   output      logic        vbus_dis_en,
   output      logic        dp_pu_en,
   output      logic        dm_pu_en,
   output      logic        dp_pd_en,
   output      logic        dm_pd_en,
   output      logic        vbus_valid_ready,
   output      logic        irq
);
   // ****************************************************************
   // Storage
   // ****************************************************************
   opcr_word_t ctrl_reg;
   opcr_stat_t irq_stat_reg;
   opcr_stat_t irq_stat_next;
   opcr_stat_t irq_mask_reg;
   opcr_word_t rdata_reg;
   opcr_word_t rdata_next;
   logic [10:0] wait_reg;
   logic        drive_prev_reg;
   logic        vbus_drive;

   opcr_stat_if stat ();

   opcr_stat_sampler u_sampler (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .vbus_level_in (vbus_level_in),
      .id_float_in   (id_float_in),
      .vbus_valid_in (vbus_valid_in),
      .stat          (stat)
   );

   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   assign wr_ctrl = reg_wr && (reg_addr == `OPCR_CTRL_ADDR);
   assign wr_stat = reg_wr && (reg_addr == `OPCR_IRQ_STAT_ADDR);
   assign wr_mask = reg_wr && (reg_addr == `OPCR_IRQ_MASK_ADDR);

   // ****************************************************************
   // Control register
   // ****************************************************************
   // Reserved and status positions of the write data are dropped
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_reg <= `OPCR_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= reg_wdata & `OPCR_CTRL_WMASK;
      end
   end

   // ****************************************************************
   // Transceiver controls
   // ****************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         vbus_pu_en     <= 1'b0;
         rx_power_down  <= 1'b0;
         charge_pump_on <= 1'b0;
         vbus_dis_en    <= 1'b0;
      end else begin
         vbus_pu_en     <= ctrl_reg[`OPCR_VBUS_PU_BIT];
         rx_power_down  <= ctrl_reg[`OPCR_RX_DIS_BIT];
         charge_pump_on <= ctrl_reg[`OPCR_CPUMP_BIT];
         vbus_dis_en    <= ctrl_reg[`OPCR_VBUS_DIS_BIT];
      end
   end

   // Data-line enables always come from this register; general port
   // settings are accepted only so the override point is explicit
   logic gen_unused;
   assign gen_unused = gen_dp_pu | gen_dm_pu | gen_dp_pd | gen_dm_pd;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dp_pu_en <= 1'b0;
         dm_pu_en <= 1'b0;
         dp_pd_en <= 1'b0;
         dm_pd_en <= 1'b0;
      end else begin
         dp_pu_en <= ctrl_reg[`OPCR_DP_PU_BIT];
         dm_pu_en <= ctrl_reg[`OPCR_DM_PU_BIT];
         dp_pd_en <= ctrl_reg[`OPCR_DP_PD_BIT];
         dm_pd_en <= ctrl_reg[`OPCR_DM_PD_BIT];
      end
   end

   // ****************************************************************
   // VBUS settle timer
   // ****************************************************************
   // Advisory only: firmware still owns the wait, this flags when done
   assign vbus_drive = ctrl_reg[`OPCR_CPUMP_BIT];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         drive_prev_reg <= 1'b0;
         wait_reg       <= 11'h000;
      end else begin
         drive_prev_reg <= vbus_drive;
         if (!vbus_drive) begin
            wait_reg <= 11'h000;
         end else if (!drive_prev_reg) begin
            wait_reg <= 11'(`OPCR_VLD_WAIT_CYC);
         end else if (wait_reg != 11'h000) begin
            wait_reg <= wait_reg - 11'h001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         vbus_valid_ready <= 1'b0;
      end else begin
         vbus_valid_ready <= vbus_drive && drive_prev_reg
                             && (wait_reg == 11'h000);
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   // A change in the same cycle as a clear keeps its bit set
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (wr_stat) begin
         irq_stat_next = irq_stat_next & ~reg_wdata[2:0];
      end
      irq_stat_next = irq_stat_next | stat.changed;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_stat_reg <= `OPCR_IRQ_RESET;
      end else begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_mask_reg <= `OPCR_IRQ_RESET;
      end else if (wr_mask) begin
         irq_mask_reg <= reg_wdata[2:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   always_comb begin
      rdata_next = 16'h0000;
      unique case (reg_addr)
         `OPCR_CTRL_ADDR: begin
            rdata_next = ctrl_reg;
            rdata_next[`OPCR_VBUS_LVL_BIT] =
               stat.level[`OPCR_VBUS_LVL_BIT];
            rdata_next[`OPCR_ID_BIT] = stat.level[`OPCR_ID_BIT];
            rdata_next[`OPCR_VBUS_VLD_BIT] =
               stat.level[`OPCR_VBUS_VLD_BIT];
         end
         `OPCR_IRQ_STAT_ADDR: begin
            rdata_next = {13'h0000, irq_stat_reg};
         end
         `OPCR_IRQ_MASK_ADDR: begin
            rdata_next = {13'h0000, irq_mask_reg};
         end
         default: begin
            rdata_next = 16'h0000;
         end
      endcase
   end

   // Data stands for exactly one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_reg <= 16'h0000;
      end else if (reg_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign reg_rdata = rdata_reg;
endmodule

/* core/opcr_stat_if.sv */
// Purpose: Carries live transceiver status between the modules
// Assumes: Single clock domain
// Notes:   Source drives, sink reads
interface opcr_stat_if;
   import opcr_pkg::*;
   opcr_stat_t level;
   opcr_stat_t changed;
   modport source (output level, output changed);
   modport sink   (input  level, input  changed);
endinterface

/* core/opcr_stat_sampler.sv */
// Purpose: Registers transceiver status inputs and flags changes
// Assumes: Inputs already synchronous to sys_clk
// Notes:   Change pulses last one cycle
`include "opcr_map.svh"
module opcr_stat_sampler
   import opcr_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic vbus_level_in,
   input  wire logic id_float_in,
   input  wire logic vbus_valid_in,
   opcr_stat_if.source stat
);
   opcr_stat_t raw;
   opcr_stat_t sample_reg;
   logic       primed_reg;

   assign raw[`OPCR_VBUS_LVL_BIT] = vbus_level_in;
   assign raw[`OPCR_ID_BIT]       = id_float_in;
   assign raw[`OPCR_VBUS_VLD_BIT] = vbus_valid_in;

   // Status carries no reset value; only the change detector is held
   always_ff @(posedge sys_clk) begin
      sample_reg <= raw;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         primed_reg <= 1'b0;
      end else begin
         primed_reg <= 1'b1;
      end
   end

   assign stat.level = raw;
   // Suppress the first compare so power-up does not raise events
   assign stat.changed = primed_reg ? (raw ^ sample_reg) : 3'h0;
endmodule

/* verif/opcr_port_ctrl_properties.sv */
// Purpose: Port-level checks of the port control register
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only the top module ports
module opcr_port_ctrl_chk (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        vbus_level_in,
   input wire logic        id_float_in,
   input wire logic        vbus_valid_in,
   input wire logic        vbus_pu_en,
   input wire logic        rx_power_down,
   input wire logic        charge_pump_on,
   input wire logic        vbus_dis_en,
   input wire logic        dp_pu_en,
   input wire logic        dm_pu_en,
   input wire logic        dp_pd_en,
   input wire logic        dm_pd_en,
   input wire logic        vbus_valid_ready,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic wr_c;
   logic rd_c;
   assign wr_c = reg_wr && reg_addr == 16'hC098;
   assign rd_c = reg_rd && reg_addr == 16'hC098;

   // Cycles the pump has been on; saturates so a long run cannot wrap
   logic [10:0] pump_cnt_reg;
   always_ff @(posedge sys_clk) begin
      if (rst || !charge_pump_on) begin
         pump_cnt_reg <= 11'h000;
      end else if (pump_cnt_reg != 11'h7FF) begin
         pump_cnt_reg <= pump_cnt_reg + 11'h001;
      end
   end

   AST_VBUS_PU: assert property (
      wr_c |-> ##2 vbus_pu_en == $past(reg_wdata[13], 2))
      else $error("vbus pull-up enable wrong");
   AST_RX_PD: assert property (
      wr_c |-> ##2 rx_power_down == $past(reg_wdata[12], 2))
      else $error("receiver power-down wrong");
   AST_CPUMP: assert property (
      wr_c |-> ##2 charge_pump_on == $past(reg_wdata[11], 2))
      else $error("charge pump enable wrong");
   AST_VBUS_DIS: assert property (
      wr_c |-> ##2 vbus_dis_en == $past(reg_wdata[10], 2))
      else $error("discharge enable wrong");
   AST_DATA_LINES: assert property (
      wr_c |-> ##2 {dp_pu_en, dm_pu_en, dp_pd_en, dm_pd_en}
         == $past(reg_wdata[9:6], 2))
      else $error("data line resistor enables wrong");
   AST_RD_STATUS: assert property (
      rd_c |=> reg_rdata[2:0]
         == $past({vbus_level_in, id_float_in, vbus_valid_in}))
      else $error("status bits in read data wrong");
   AST_RSVD_ZERO: assert property (
      rd_c |=> reg_rdata[15:14] == 2'h0 && reg_rdata[5:3] == 3'h0)
      else $error("reserved bits read nonzero");
   AST_RD_IDLE: assert property (
      !$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside the answer cycle");
   AST_RESET_OUT: assert property (
      $fell(rst) |-> {vbus_pu_en, rx_power_down, charge_pump_on,
         vbus_dis_en, dp_pu_en, dm_pu_en, dp_pd_en, dm_pd_en, irq} == 9'h000)
      else $error("outputs not cleared by reset");
   // Ready may only show after the pump has run a full 10 us (1250 cycles)
   AST_READY_WAIT: assert property (
      vbus_valid_ready |-> charge_pump_on && pump_cnt_reg >= 11'h4E2)
      else $error("vbus valid ready too early");
endmodule

bind opcr_port_ctrl opcr_port_ctrl_chk opcr_port_ctrl_chk_i (
   .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .vbus_level_in, .id_float_in, .vbus_valid_in, .vbus_pu_en,
   .rx_power_down, .charge_pump_on, .vbus_dis_en, .dp_pu_en, .dm_pu_en,
   .dp_pd_en, .dm_pd_en, .vbus_valid_ready, .irq);

/* verif/opcr_xcvr_model.sv */
// Purpose: Behavioural transceiver and VBUS supply of the port
// Assumes: VBUS ramps one step per clock while the pump runs
// Notes:   Ramp is shorter than the settle wait on purpose
module opcr_xcvr_model (
   input  wire logic sys_clk,
   input  wire logic charge_pump_on,
   input  wire logic id_gnd,
   output      logic vbus_level_in,
   output      logic id_float_in,
   output      logic vbus_valid_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] vbus_reg = 10'h000;
   always_ff @(posedge sys_clk) begin
      if (charge_pump_on && vbus_reg != 10'h3FF)
         vbus_reg <= vbus_reg + 10'h001;
      else if (!charge_pump_on && vbus_reg != 10'h000)
         vbus_reg <= vbus_reg - 10'h001;
   end
   // Thresholds scaled to a 5 V full swing
   assign vbus_level_in = vbus_reg > 10'h1EA;
   assign vbus_valid_in = vbus_reg > 10'h380;
   assign id_float_in   = !id_gnd;
endmodule

/* verif/tb.sv */
// Purpose: Self-checking bench of the port control register
// Assumes: Register port strobes one cycle long
// Notes:   Reserved bits written as zero except in one refusal case
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import opcr_pkg::*;
   logic       sys_clk, rst, reg_wr, reg_rd, id_gnd, irq, rdy;
   logic       vbus_level_in, id_float_in, vbus_valid_in;
   logic [3:0] gen;
   logic [7:0] en;
   opcr_word_t reg_addr, reg_wdata, reg_rdata, w, d, s;
   integer     seed = 34305;
   int         n_mismatch = 0;
   int         num_checks = 0;

   opcr_port_ctrl opcr_port_ctrl_i (.sys_clk, .rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .vbus_level_in, .id_float_in,
      .vbus_valid_in, .gen_dp_pu(gen[3]), .gen_dm_pu(gen[2]),
      .gen_dp_pd(gen[1]), .gen_dm_pd(gen[0]), .vbus_pu_en(en[7]),
      .rx_power_down(en[6]), .charge_pump_on(en[5]), .vbus_dis_en(en[4]),
      .dp_pu_en(en[3]), .dm_pu_en(en[2]), .dp_pd_en(en[1]),
      .dm_pd_en(en[0]), .vbus_valid_ready(rdy), .irq);
   opcr_xcvr_model opcr_xcvr_model_i (.sys_clk, .charge_pump_on(en[5]),
      .id_gnd, .vbus_level_in, .id_float_in, .vbus_valid_in);

   // ****************************************************************
   // Bus tasks and comparison
   // ****************************************************************
   task automatic chk(input opcr_word_t seen, exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input opcr_word_t a, v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Status captured at the strobe edge, where the design samples it
   task automatic rd(input opcr_word_t a, output opcr_word_t q, st);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      st = {13'h0000, vbus_level_in, id_float_in, vbus_valid_in};
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      q = reg_rdata;
      @(posedge sys_clk);
   endtask
   function automatic opcr_word_t exp_rd(opcr_word_t v, st);
      return (v & 16'h3FC0) | st;
   endfunction
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      id_gnd = 1'b0;
      gen = 4'hF;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(16'hC098, d, s);
      chk(d, s, "ctrl after reset");
      chk({8'h00, en}, 16'h0000, "enables after reset");
      $display("Test reset done");
      for (int i = 0; i < 24; i++) begin
         // First pass writes every reserved bit to prove they are ignored
         w = (i == 0) ? 16'hFFFF : 16'($random(seed)) & 16'h3FC7;
         gen <= 4'($random(seed));
         id_gnd <= 1'($random(seed));
         wr(16'hC098, w);
         rd(16'hC098, d, s);
         chk(d, exp_rd(w, s), "ctrl readback");
         chk({8'h00, en}, {8'h00, w[13:6]}, "enables");
      end
      wr(16'hC0A0, 16'h3FC0);
      rd(16'hC0A0, d, s);
      chk(d, 16'h0000, "unmapped read");
      rd(16'hC098, d, s);
      chk(d, exp_rd(w, s), "ctrl kept");
      $display("Test random control done");
      id_gnd <= 1'b0;
      wr(16'hC098, 16'h0000);
      repeat (1100) @(posedge sys_clk);
      wr(16'hC09A, 16'h0007);
      rd(16'hC09C, d, s);
      chk(d, 16'h0000, "mask reset");
      wr(16'hC09C, 16'h0002);
      rd(16'hC09A, d, s);
      chk(d, 16'h0000, "status cleared");
      id_gnd <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk({15'h0000, irq}, 16'h0001, "irq raised");
      wr(16'hC09C, 16'h0000);
      id_gnd <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk({15'h0000, irq}, 16'h0000, "irq masked");
      rd(16'hC09A, d, s);
      chk(d, 16'h0002, "status id change");
      wr(16'hC09A, 16'h0002);
      rd(16'hC09A, d, s);
      chk(d, 16'h0000, "status write one clear");
      $display("Test interrupt done");
      // Firmware honours the settle wait before trusting VBUS valid
      wr(16'hC098, 16'h0800);
      // Just short of 10 us of pump time the advisory must still be low
      repeat (1249) @(posedge sys_clk);
      chk({15'h0000, rdy}, 16'h0000, "ready early");
      repeat (51) @(posedge sys_clk);
      chk({15'h0000, rdy}, 16'h0001, "ready");
      rd(16'hC098, d, s);
      chk(d, 16'h0807, "vbus valid read");
      $display("Test charge pump done");
      tally_and_finish();
   end
endmodule
